// >>> inc/sao_pkg.sv
// sao_pkg: widths, counts and carrier types of the sampling converter
// control and serial output stage.
// assumes: included before rtl/sao_adc_serial_out.sv, no imports used.
package sao_pkg;
    // ---------------------------------------------------------------
    // result layout
    // ---------------------------------------------------------------
    localparam int RESULT_W = 18;
    localparam int MERGED_A_W = 16;
    localparam int BIT_IDX_W = 5;
    localparam logic [4:0] MSB_IDX = 5'h11;
    localparam logic [17:0] TRIAL_START = 18'h20000;
    // two's complement code anchors of the output mapping
    localparam logic [17:0] CODE_POS_FULL = 18'h1FFFF;
    localparam logic [17:0] CODE_ZERO = 18'h00000;
    localparam logic [17:0] CODE_MINUS_ONE = 18'h3FFFF;
    localparam logic [17:0] CODE_NEG_FULL = 18'h20000;

    // ---------------------------------------------------------------
    // buffering and clocking
    // ---------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_PINS = 8;
    localparam logic [1:0] OSC_DIVIDE_LAST = 2'h2;
    // host spacing figures, kept for reference; no check uses them
    localparam int MIN_TRIG_SAMPLE_TRIGGER_IN_CLOCKS = 24;
    localparam int MIN_TRIG_OSC_CYCLES = 72;
    localparam int MIN_TRIG_BIT_CLOCKS = 24;
    localparam int MIN_TRIG_BIT_CLOCKS_MERGED = 40;

    // pin positions inside the synchroniser vector
    localparam int PIN_BITCLK = 0;
    localparam int PIN_CONVCLK = 1;
    localparam int PIN_OSC = 2;
    localparam int PIN_TRIG = 3;
    localparam int PIN_TAG_A = 4;
    localparam int PIN_TAG_B = 5;
    localparam int PIN_MERGED = 6;
    localparam int PIN_POL = 7;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [17:0] a;
        logic [17:0] b;
    } sao_pair_s;

    typedef enum logic [1:0] {
        SAO_ACQUIRE,
        SAO_CONVERT,
        SAO_DONE
    } sao_sample_trigger_in_state_e;
endpackage

// >>> rtl/sao_fifo.sv
// sao_fifo: flip-flop fifo with valid/ready on both sides.
// assumes: one clock, async active-low reset, show-ahead read port.
`timescale 1ns/10ps
`default_nettype none
module sao_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_idx <= '0;
            rd_idx <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
            end
            if (pop) begin
                rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sao_fifo
`default_nettype wire

// >>> rtl/sao_adc_serial_out.sv
// sao_adc_serial_out: trigger, hold and approximation sequencing, the
// divide-by-three conversion clock and the serial result output.
// assumes: all pins arrive asynchronously and are sampled on clk
// (40 MHz); oscillator_in must stay below a third of clk for the divider
// to see every edge; comparator inputs come from the analogue core and
// settle between conversion clock edges.
//
// Operation
// - return to acquisition after each conversion
// - shift results out MSB first, two's complement
// - full scale and zero codes map as specified
// - send all 18 bits, LSBs included, except channel A in merged mode
// - tag bits follow the full result
// - merged mode: 16 A bits then 18 B
// - resynchronise data, sync and tag to bit clock
// - sync pulse on every trigger, selectable polarity
// - trigger latches result, fill strobe loads shifter
// - outputs change on bit clock rising edge
// - bit decisions on conversion clock rising edge
// - hold first, then gate conversion clock
// - divided clock is oscillator over three
// - tags shift in, appear 17 clocks later
// - merged select builds 34-bit word on A
// - sync lasts exactly one bit clock
// - one trigger holds both channels together
`timescale 1ns/10ps
`default_nettype none
module sao_adc_serial_out (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // clock pins
    input wire logic bit_clock_in,
    input wire logic conversion_clock_in,
    input wire logic oscillator_in,
    output logic crystal_drive_out,
    output logic divided_clock_out,
    // control pins
    input wire logic sample_trigger_in,
    input wire logic merged_word_select,
    input wire logic sync_polarity_select,
    input wire logic appendix_in_a,
    input wire logic appendix_in_b,
    // serial output pins
    output logic serial_result_out_a,
    output logic serial_result_out_b,
    output logic sync_pulse_out,
    // analogue core
    output logic hold_out,
    output logic decision_strobe,
    output sao_pkg::sao_pair_s trial_code,
    input wire logic comp_above_a,
    input wire logic comp_above_b
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [sao_pkg::SYNC_PINS-1:0] pin_raw;
    logic [sao_pkg::SYNC_PINS-1:0] pin_meta;
    logic [sao_pkg::SYNC_PINS-1:0] pin_sync;

    assign pin_raw = {sync_polarity_select, merged_word_select,
                      appendix_in_b, appendix_in_a, sample_trigger_in,
                      oscillator_in, conversion_clock_in, bit_clock_in};

    genvar gi;
    generate
        for (gi = 0; gi < sao_pkg::SYNC_PINS; gi++) begin : g_sync
            // first stage feeds only the second
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // edge detection
    // ---------------------------------------------------------------
    logic bitclk_d;
    logic convclk_d;
    logic osc_d;
    logic trig_d;
    logic bit_rise;
    logic sample_trigger_in_rise;
    logic osc_rise;
    logic trig_fall;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bitclk_d <= 1'b0;
            convclk_d <= 1'b0;
            osc_d <= 1'b0;
            trig_d <= 1'b0;
        end else begin
            bitclk_d <= pin_sync[sao_pkg::PIN_BITCLK];
            convclk_d <= pin_sync[sao_pkg::PIN_CONVCLK];
            osc_d <= pin_sync[sao_pkg::PIN_OSC];
            trig_d <= pin_sync[sao_pkg::PIN_TRIG];
        end
    end

    assign bit_rise = pin_sync[sao_pkg::PIN_BITCLK] && !bitclk_d;
    assign sample_trigger_in_rise = pin_sync[sao_pkg::PIN_CONVCLK] && !convclk_d;
    assign osc_rise = pin_sync[sao_pkg::PIN_OSC] && !osc_d;
    // level is ignored, one sequence per falling edge
    assign trig_fall = trig_d && !pin_sync[sao_pkg::PIN_TRIG];

    // ---------------------------------------------------------------
    // divide-by-three clock and crystal drive
    // ---------------------------------------------------------------
    logic [1:0] osc_count;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_count <= 2'h0;
            divided_clock_out <= 1'b0;
            crystal_drive_out <= 1'b1;
        end else begin
            crystal_drive_out <= !pin_sync[sao_pkg::PIN_OSC];
            if (osc_rise) begin
                if (osc_count == sao_pkg::OSC_DIVIDE_LAST) begin
                    osc_count <= 2'h0;
                    divided_clock_out <= 1'b1;
                end else begin
                    osc_count <= osc_count + 2'h1;
                    divided_clock_out <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // approximation sequencer
    // ---------------------------------------------------------------
    function automatic logic [17:0] to_twos(input logic [17:0] offset);
        // offset binary to two's complement: 20000 -> 00000, 3FFFF -> 1FFFF etc.
        to_twos = {!offset[17], offset[16:0]};
    endfunction

    sao_pkg::sao_sample_trigger_in_state_e state;
    logic [sao_pkg::BIT_IDX_W-1:0] bit_idx;
    logic [17:0] sar_a;
    logic [17:0] sar_b;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic push_valid;
    sao_pkg::sao_pair_s push_pair;
    sao_pkg::sao_pair_s pop_pair;

    assign push_valid = (state == sao_pkg::SAO_DONE);
    assign push_pair = '{a: to_twos(sar_a), b: to_twos(sar_b)};
    assign trial_code = '{a: sar_a, b: sar_b};
    // decisions are only taken while the capacitors are held
    assign decision_strobe = sample_trigger_in_rise &&
                             (state == sao_pkg::SAO_CONVERT);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= sao_pkg::SAO_ACQUIRE;
            hold_out <= 1'b0;
        end else begin
            unique case (state)
                sao_pkg::SAO_ACQUIRE: begin
                    if (trig_fall) begin
                        hold_out <= 1'b1;
                        state <= sao_pkg::SAO_CONVERT;
                    end
                end
                sao_pkg::SAO_CONVERT: begin
                    if (decision_strobe && bit_idx == '0) begin
                        state <= sao_pkg::SAO_DONE;
                    end
                end
                sao_pkg::SAO_DONE: begin
                    // a full buffer keeps the channels in hold
                    if (fifo_in_ready) begin
                        hold_out <= 1'b0;
                        state <= sao_pkg::SAO_ACQUIRE;
                    end
                end
                default: begin
                    hold_out <= 1'b0;
                    state <= sao_pkg::SAO_ACQUIRE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_idx <= sao_pkg::MSB_IDX;
            sar_a <= sao_pkg::TRIAL_START;
            sar_b <= sao_pkg::TRIAL_START;
        end else if (state == sao_pkg::SAO_ACQUIRE && trig_fall) begin
            bit_idx <= sao_pkg::MSB_IDX;
            sar_a <= sao_pkg::TRIAL_START;
            sar_b <= sao_pkg::TRIAL_START;
        end else if (decision_strobe) begin
            // keep or drop the trial bit, then try the next one
            if (!comp_above_a) begin
                sar_a[bit_idx] <= 1'b0;
            end
            if (!comp_above_b) begin
                sar_b[bit_idx] <= 1'b0;
            end
            if (bit_idx != '0) begin
                sar_a[bit_idx - 5'h01] <= 1'b1;
                sar_b[bit_idx - 5'h01] <= 1'b1;
                bit_idx <= bit_idx - 5'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // result buffer
    // ---------------------------------------------------------------
    sao_fifo #(
        .WIDTH(2 * sao_pkg::RESULT_W),
        .DEPTH(sao_pkg::FIFO_DEPTH)
    ) u_result_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(push_valid),
        .in_ready(fifo_in_ready),
        .in_data(push_pair),
        .out_valid(fifo_out_valid),
        .out_ready(trig_fall),
        .out_data(pop_pair)
    );

    // ---------------------------------------------------------------
    // holding latch and fill strobe
    // ---------------------------------------------------------------
    sao_pkg::sao_pair_s hold_latch;
    logic fill_pending;
    logic fill_strobe;

    // the previous result leaves the buffer on the trigger edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hold_latch <= '0;
        end else if (trig_fall && fifo_out_valid) begin
            hold_latch <= pop_pair;
        end
    end

    // a new trigger wins over the load that clears the request
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fill_pending <= 1'b0;
        end else if (trig_fall) begin
            fill_pending <= 1'b1;
        end else if (bit_rise) begin
            fill_pending <= 1'b0;
        end
    end

    assign fill_strobe = bit_rise && fill_pending;

    // ---------------------------------------------------------------
    // output shift registers
    // ---------------------------------------------------------------
    logic [17:0] shift_a;
    logic [17:0] shift_b;
    logic merged_mode;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            merged_mode <= 1'b0;
            shift_a <= '0;
            shift_b <= '0;
        end else if (fill_strobe) begin
            // mode is sampled per frame so a word never mixes layouts
            merged_mode <= pin_sync[sao_pkg::PIN_MERGED];
            shift_b <= hold_latch.b;
            if (pin_sync[sao_pkg::PIN_MERGED]) begin
                shift_a <= {2'h0, hold_latch.a[17:2]};
            end else begin
                shift_a <= hold_latch.a;
            end
        end else if (bit_rise) begin
            shift_b <= {shift_b[16:0],
                        pin_sync[sao_pkg::PIN_TAG_B]};
            if (merged_mode) begin
                // channel B follows the 16 A bits, then its tag
                shift_a <= {2'h0, shift_a[14:0], shift_b[17]};
            end else begin
                shift_a <= {shift_a[16:0],
                            pin_sync[sao_pkg::PIN_TAG_A]};
            end
        end
    end

    // ---------------------------------------------------------------
    // pin registers
    // ---------------------------------------------------------------
    // outputs move one clk after the sampled rise, well ahead of the
    // next rising edge the receiver samples on
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_result_out_a <= 1'b0;
            serial_result_out_b <= 1'b0;
            sync_pulse_out <= 1'b0;
        end else if (fill_strobe) begin
            serial_result_out_a <= pin_sync[sao_pkg::PIN_MERGED] ?
                hold_latch.a[17] : hold_latch.a[17];
            serial_result_out_b <= hold_latch.b[17];
            sync_pulse_out <= pin_sync[sao_pkg::PIN_POL];
        end else if (bit_rise) begin
            serial_result_out_a <= merged_mode ?
                shift_a[14] : shift_a[16];
            serial_result_out_b <= shift_b[16];
            sync_pulse_out <= !pin_sync[sao_pkg::PIN_POL];
        end
    end
endmodule // sao_adc_serial_out
`default_nettype wire

// >>> tb/sao_adc_serial_out_asserts.sv
// sao_adc_serial_out_asserts: port-level checks of the serial output stage.
// assumes: bound to sao_adc_serial_out, one clk domain, async reset_n.
`timescale 1ns/10ps
`default_nettype none
module sao_adc_serial_out_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic bit_clock_in,
    input wire logic oscillator_in,
    input wire logic divided_clock_out,
    input wire logic crystal_drive_out,
    input wire logic sample_trigger_in,
    input wire logic sync_polarity_select,
    input wire logic serial_result_out_a,
    input wire logic serial_result_out_b,
    input wire logic sync_pulse_out,
    // core side
    input wire logic hold_out,
    input wire logic decision_strobe
);
    // ---------------------------------------------------------------
    // helper counters
    // ---------------------------------------------------------------
    logic act, div_seen;
    logic [4:0] dec_cnt;
    logic [1:0] sync_cnt;
    logic [2:0] osc_cnt;
    logic [3:0] brise_age;
    logic [5:0] since_trig;
    assign act = (sync_pulse_out == sync_polarity_select);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dec_cnt <= 5'h00;
            sync_cnt <= 2'h0;
            osc_cnt <= 3'h0;
            div_seen <= 1'b0;
            brise_age <= 4'hF;
            since_trig <= 6'h3F;
        end else begin
            dec_cnt <= !hold_out ? 5'h00 : dec_cnt + 5'(decision_strobe);
            sync_cnt <= !act ? 2'h0 :
                sync_cnt + 2'($rose(bit_clock_in) && sync_cnt != 2'h3);
            osc_cnt <= $rose(divided_clock_out) ? 3'($rose(oscillator_in)) :
                osc_cnt + 3'($rose(oscillator_in) && osc_cnt != 3'h7);
            div_seen <= div_seen | $rose(divided_clock_out);
            brise_age <= $rose(bit_clock_in) ? 4'h0 :
                brise_age + 4'(brise_age != 4'hF);
            since_trig <= $fell(sample_trigger_in) ? 6'h00 :
                since_trig + 6'(since_trig != 6'h3F);
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_trig_idle;
        $fell(sample_trigger_in) && !hold_out;
    endsequence
    sequence s_last_decision;
        decision_strobe && dec_cnt == 5'h11;
    endsequence
    AST_HOLD_ON_TRIG: assert property (s_trig_idle |-> ##[2:5] hold_out)
        else $error("hold not entered after trigger");
    AST_DECIDE_IN_HOLD: assert property (decision_strobe |-> hold_out && dec_cnt < 5'h12)
        else $error("decision outside hold or beyond eighteen");
    AST_RELEASE: assert property (s_last_decision |-> ##[1:4] !hold_out)
        else $error("acquisition not resumed after last decision");
    AST_HOLD_DROP: assert property ($fell(hold_out) |-> dec_cnt == 5'h12)
        else $error("hold released before eighteen decisions");
    // first divider edge after reset has no full history, so it is skipped
    AST_DIV3: assert property ($rose(divided_clock_out) && div_seen |-> osc_cnt == 3'h3)
        else $error("divided clock is not oscillator over three");
    // drive is the oscillator inverted after sync and output register
    AST_XTAL_DRIVE: assert property ($past(reset_n, 3) |-> crystal_drive_out == !$past(oscillator_in, 3))
        else $error("crystal drive is not the inverted oscillator");
    AST_SYNC_ONE: assert property (act |-> sync_cnt <= 2'h1)
        else $error("sync active longer than one bit clock");
    AST_TRIG_SYNC: assert property ($fell(sample_trigger_in) |-> ##[2:30] act)
        else $error("no sync after trigger");
    AST_NO_SPURIOUS: assert property ($rose(act) && $stable(sync_polarity_select) |-> since_trig <= 6'h1E)
        else $error("sync without trigger");
    AST_DATA_ON_BIT: assert property (!$stable({serial_result_out_a, serial_result_out_b}) |-> brise_age <= 4'h5)
        else $error("serial data moved away from bit clock rise");
    AST_SYNC_ON_BIT: assert property (!$stable(sync_pulse_out) |-> brise_age <= 4'h5)
        else $error("sync moved away from bit clock rise");
endmodule // sao_adc_serial_out_asserts

bind sao_adc_serial_out sao_adc_serial_out_asserts u_asserts (
    .clk(clk), .reset_n(reset_n), .bit_clock_in(bit_clock_in),
    .oscillator_in(oscillator_in), .divided_clock_out(divided_clock_out),
    .crystal_drive_out(crystal_drive_out),
    .sample_trigger_in(sample_trigger_in),
    .sync_polarity_select(sync_polarity_select),
    .serial_result_out_a(serial_result_out_a),
    .serial_result_out_b(serial_result_out_b),
    .sync_pulse_out(sync_pulse_out), .hold_out(hold_out),
    .decision_strobe(decision_strobe)
);
`default_nettype wire

// >>> tb/sao_dsp_port.sv
// sao_dsp_port: behavioural serial receive port of a signal processor.
// assumes: bench clk; makes the bit clock, 8 clk period or 12 when slow.
`timescale 1ns/10ps
`default_nettype none
module sao_dsp_port (
    // clock
    input wire logic clk,
    input wire logic slow,
    // link
    output logic bit_clock,
    input wire logic sync_polarity,
    input wire logic sync_in,
    input wire logic data_a,
    input wire logic data_b,
    // captured 40-bit words
    output logic [39:0] word_a,
    output logic [39:0] word_b,
    output logic [7:0] frames
);
    // ---------------------------------------------------------------
    // bit clock and capture
    // ---------------------------------------------------------------
    int half_cnt, bit_cnt;
    logic prev_sync;
    logic [39:0] sh_a, sh_b;
    initial begin
        bit_clock = 1'b0;
        frames = 8'h00;
        half_cnt = 0;
        bit_cnt = 0;
        prev_sync = 1'b0;
    end
    // runs free: tags keep moving in between frames
    always @(negedge clk) begin
        half_cnt++;
        if (half_cnt >= (slow ? 6 : 4)) begin
            half_cnt = 0;
            bit_clock = ~bit_clock;
        end
    end
    // start on a change of sync into its active level only, so that a
    // polarity change alone never opens a frame
    always @(posedge bit_clock) begin
        if (bit_cnt > 0) begin
            sh_a = {sh_a[38:0], data_a};
            sh_b = {sh_b[38:0], data_b};
            bit_cnt++;
        end else if (sync_in === sync_polarity && sync_in !== prev_sync) begin
            sh_a = {39'h0, data_a};
            sh_b = {39'h0, data_b};
            bit_cnt = 1;
        end
        if (bit_cnt == 40) begin
            word_a = sh_a;
            word_b = sh_b;
            bit_cnt = 0;
            frames++;
        end
        prev_sync = sync_in;
    end
endmodule // sao_dsp_port
`default_nettype wire

// >>> tb/test_sao_adc_serial_out.sv
// test_sao_adc_serial_out: self-checking bench of the serial output stage.
// assumes: sao_pkg, design, checker and partner compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_sao_adc_serial_out;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic clk, reset_n, osc, div_clk, bit_clk, trig, merged, pol;
    logic tag_a, tag_b, slow, sa, sb, sync, hold, dstrobe, skip;
    sao_pkg::sao_pair_s trial;
    logic [17:0] tgt_a, tgt_b, ca, cb, pa, pb;
    logic [17:0] codes [4] = '{18'h1FFFF, 18'h00000, 18'h3FFFF, 18'h20000};
    logic [39:0] word_a, word_b;
    logic [7:0] frames, seen;
    logic [79:0] exp_q[$];
    logic [79:0] e;
    logic [2:0] osc_cnt;
    int num_errors, n_compared;

    // comparator keeps the bit when the input is at or above the trial
    sao_adc_serial_out uut (
        .clk(clk), .reset_n(reset_n), .bit_clock_in(bit_clk),
        .conversion_clock_in(div_clk), .oscillator_in(osc),
        .crystal_drive_out(), .divided_clock_out(div_clk),
        .sample_trigger_in(trig), .merged_word_select(merged),
        .sync_polarity_select(pol), .appendix_in_a(tag_a),
        .appendix_in_b(tag_b), .serial_result_out_a(sa),
        .serial_result_out_b(sb), .sync_pulse_out(sync), .hold_out(hold),
        .decision_strobe(dstrobe), .trial_code(trial),
        .comp_above_a(trial.a <= tgt_a), .comp_above_b(trial.b <= tgt_b)
    );
    sao_dsp_port dsp (
        .clk(clk), .slow(slow), .bit_clock(bit_clk), .sync_polarity(pol),
        .sync_in(sync), .data_a(sa), .data_b(sb), .word_a(word_a),
        .word_b(word_b), .frames(frames)
    );

    // ---------------------------------------------------------------
    // clocks, checks and closing
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // oscillator at six clk per period, half the fastest rate the divider allows
    always @(negedge clk) begin
        osc_cnt = (osc_cnt == 3'h2) ? 3'h0 : osc_cnt + 3'h1;
        if (osc_cnt == 3'h0) osc = ~osc;
    end
    task automatic check(input string what, input logic [39:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // first frame carries the latch's reset content, so it is skipped
    always @(posedge clk) begin
        if (frames !== seen) begin
            seen = frames;
            if (skip) begin
                skip = 1'b0;
            end else if (exp_q.size() == 0) begin
                check("frame_count", 40'h0, 40'h1);
            end else begin
                e = exp_q.pop_front();
                check("serial_result_out_a", e[79:40], word_a);
                check("serial_result_out_b", e[39:0], word_b);
            end
        end
    end

    // ---------------------------------------------------------------
    // stimulus: one frame per trigger, 720 clk apart
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(43));
        {reset_n, merged, tag_a, tag_b, slow, osc} = 6'h00;
        {trig, pol, skip} = 3'h7;
        {tgt_a, tgt_b, osc_cnt, seen} = 47'h0;
        num_errors = 0;
        n_compared = 0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        for (int k = 0; k < 18; k++) begin
            ca = k < 4 ? codes[k] : 18'($urandom());
            cb = k < 4 ? codes[3 - k] : 18'($urandom());
            merged = k >= 8 ? 1'(k % 2) : 1'b0;
            pol = k < 4 ? 1'b1 : 1'($urandom());
            {tag_a, tag_b} = 2'($urandom());
            slow = (k >= 12);
            tgt_a = ca ^ 18'h20000;
            tgt_b = cb ^ 18'h20000;
            if (k > 0) begin
                exp_q.push_back({merged ? {pa[17:2], pb, {6{tag_b}}} :
                    {pa, {22{tag_a}}}, pb, {22{tag_b}}});
            end
            pa = ca;
            pb = cb;
            repeat (160) @(negedge clk);
            trig = 1'b0;
            repeat (4) @(negedge clk);
            trig = 1'b1;
            repeat (556) @(negedge clk);
        end
        check("frames_left", 40'h0, 40'(exp_q.size()));
        end_of_test();
    end
    initial begin
        #750000;
        num_errors++;
        $display("ERROR watchdog expected end seen hang");
        end_of_test();
    end
endmodule // test_sao_adc_serial_out
`default_nettype wire
